//--- src/decode_pkg.sv
package decode_pkg;
  // widths
  localparam int XLEN      = 32;
  localparam int NREGS     = 32;
  localparam int REG_IDX_W = 5;
  localparam int OPC_W     = 6;
  localparam int FUNCT_W   = 6;
  localparam int SHAMT_W   = 5;
  localparam int IMM_W     = 16;
  localparam int JT_W      = 26;
  localparam int PAGE_W    = 4;
  localparam int WORD_SH   = 2;
  localparam int STAGES    = 5;
  localparam int CODE_W    = 5;
  localparam int CLS_W     = 5;
  localparam int FMT_W     = 3;
  localparam int SEG_W     = 3;
  // field positions
  localparam int OPC_HI = 31, OPC_LO = 26;
  localparam int SRC_HI = 25, SRC_LO = 21;
  localparam int TGT_HI = 20, TGT_LO = 16;
  localparam int DST_HI = 15, DST_LO = 11;
  localparam int SHM_HI = 10, SHM_LO = 6;
  localparam int FN_HI  = 5,  FN_LO  = 0;
  localparam int IMM_HI = 15, IMM_LO = 0;
  localparam int JT_HI  = 25, JT_LO  = 0;
  // constants of the datapath
  localparam logic [XLEN-1:0]      RESET_PC  = 32'h0000_0000;
  localparam logic [XLEN-1:0]      WORD_STEP = 32'h0000_0004;
  localparam logic [REG_IDX_W-1:0] LINK_IDX  = 5'h1f;
  localparam logic [XLEN-1:0]      SEG_MASK  = 32'h1fff_ffff;
  localparam logic [SEG_W-1:0]     SEG_K0    = 3'h4;
  localparam logic [SEG_W-1:0]     SEG_K1    = 3'h5;
  // opcodes
  localparam logic [OPC_W-1:0] OP_SPECIAL = 6'h00, OP_REGIMM = 6'h01;
  localparam logic [OPC_W-1:0] OP_J = 6'h02, OP_JAL = 6'h03, OP_BEQ = 6'h04;
  localparam logic [OPC_W-1:0] OP_BNE = 6'h05, OP_BLEZ = 6'h06, OP_BGTZ = 6'h07;
  localparam logic [OPC_W-1:0] OP_ALUI_LO = 6'h08, OP_ALUI_HI = 6'h0f;
  localparam logic [OPC_W-1:0] OP_COP_LO = 6'h10, OP_COP_HI = 6'h13;
  localparam logic [OPC_W-1:0] OP_LD_LO = 6'h20, OP_LD_HI = 6'h26;
  localparam logic [OPC_W-1:0] OP_SB = 6'h28, OP_SH = 6'h29, OP_SWL = 6'h2a;
  localparam logic [OPC_W-1:0] OP_SW = 6'h2b, OP_SWR = 6'h2e;
  localparam logic [OPC_W-1:0] OP_LWC_LO = 6'h30, OP_LWC_HI = 6'h33;
  localparam logic [OPC_W-1:0] OP_SWC_LO = 6'h38, OP_SWC_HI = 6'h3b;
  // register-form functions
  localparam logic [FUNCT_W-1:0] FN_SLL = 6'h00, FN_SRL = 6'h02, FN_SRA = 6'h03;
  localparam logic [FUNCT_W-1:0] FN_SLLV = 6'h04, FN_SRLV = 6'h06, FN_SRAV = 6'h07;
  localparam logic [FUNCT_W-1:0] FN_JR = 6'h08, FN_JALR = 6'h09;
  localparam logic [FUNCT_W-1:0] FN_SYSCALL = 6'h0c, FN_BREAK = 6'h0d;
  localparam logic [FUNCT_W-1:0] FN_MFHI = 6'h10, FN_MTHI = 6'h11;
  localparam logic [FUNCT_W-1:0] FN_MFLO = 6'h12, FN_MTLO = 6'h13;
  localparam logic [FUNCT_W-1:0] FN_MD_LO = 6'h18, FN_MD_HI = 6'h1b;
  localparam logic [FUNCT_W-1:0] FN_AL_LO = 6'h20, FN_AL_HI = 6'h27;
  localparam logic [FUNCT_W-1:0] FN_SLT = 6'h2a, FN_SLTU = 6'h2b;
  // branch-on-sign selectors in the target field
  localparam logic [REG_IDX_W-1:0] RI_BLTZ = 5'h00, RI_BGEZ = 5'h01;
  localparam logic [REG_IDX_W-1:0] RI_BLTZAL = 5'h10, RI_BGEZAL = 5'h11;
  // cause codes and status bits
  localparam logic [CODE_W-1:0] EXC_NONE = 5'h00, EXC_SYS = 5'h08, EXC_BRK = 5'h09;
  localparam logic [CODE_W-1:0] EXC_RI = 5'h0a, EXC_OV = 5'h0c;
  localparam int CAUSE_CODE_LO = 2;
  localparam int STAT_EXC_BIT  = 0;
  localparam int STAT_BE_BIT   = 1;

  typedef enum logic [CLS_W-1:0] {
    CLS_LDST = 5'b00001,
    CLS_COMP = 5'b00010,
    CLS_FLOW = 5'b00100,
    CLS_COP  = 5'b01000,
    CLS_SPEC = 5'b10000
  } class_e;

  typedef enum logic [FMT_W-1:0] {
    FMT_I = 3'b001,
    FMT_J = 3'b010,
    FMT_R = 3'b100
  } fmt_e;

  typedef struct packed {
    logic [OPC_W-1:0]     opcode_field;
    logic [REG_IDX_W-1:0] source_reg_field;
    logic [REG_IDX_W-1:0] target_reg_field;
    logic [REG_IDX_W-1:0] dest_field;
    logic [SHAMT_W-1:0]   shamt_field;
    logic [FUNCT_W-1:0]   funct_field;
    logic [XLEN-1:0]      imm_sext;
    logic [JT_W-1:0]      jump_field;
    class_e               cls;
    fmt_e                 fmt;
    logic                 reserved;
    logic                 is_load;
    logic                 is_store;
    logic                 wr_en;
    logic [REG_IDX_W-1:0] wr_idx;
  } dec_s;

  typedef struct packed {
    logic [NREGS-1:0][XLEN-1:0] gpr;
    logic [XLEN-1:0]            pc;
    logic [XLEN-1:0]            hi;
    logic [XLEN-1:0]            lo;
    dec_s                       dec;
    logic [XLEN-1:0]            src_val;
    logic [XLEN-1:0]            tgt_val;
    logic [XLEN-1:0]            eff_addr;
    logic [XLEN-1:0]            phys_addr;
    logic [XLEN-1:0]            flow_target;
    logic                       redirect;
    logic [XLEN-1:0]            status;
    logic [XLEN-1:0]            cause;
    logic                       big_endian;
    logic                       strap_done;
    logic [STAGES-1:0]          stage_valid;
  } state_s;
endpackage

//--- src/risc_format_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - 32 gprs, pc, multiply/divide hi lo
// - 32-bit words in three fixed layouts
// - fixed field positions per layout
// - loads/stores: base plus signed offset
// - alu ops register or immediate layout
// - computational writes only its destination
// - jump target: pc page plus field
// - register jump takes full register value
// - branch target pc-relative from displacement
// - jal and branch-and-link write return to link_register, jalr to its destination field
// - coprocessor loads/stores immediate layout
// - special instructions use register layout
// - five-stage pipeline, precise stall handling
// - no tlb, fixed segment mapping
// - no condition codes, branches test registers
// - caches answer within one cycle
// - exceptions recorded in status and cause
// - byte order chosen at reset
module risc_format_decoder
  import decode_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       big_endian_strap,
  input  wire logic                       fetch_valid,
  input  wire logic [decode_pkg::XLEN-1:0] fetch_instr,
  output logic                            fetch_ready,
  output logic [decode_pkg::XLEN-1:0]     fetch_pc,
  input  wire logic                       stall,
  input  wire logic                       wb_valid,
  input  wire logic [decode_pkg::REG_IDX_W-1:0] wb_idx,
  input  wire logic [decode_pkg::XLEN-1:0] wb_data,
  input  wire logic                       muldiv_valid,
  input  wire logic [decode_pkg::XLEN-1:0] muldiv_hi,
  input  wire logic [decode_pkg::XLEN-1:0] muldiv_lo,
  input  wire logic                       ovf_event,
  input  wire logic                       exc_ack,
  output decode_pkg::dec_s                dec_out,
  output logic [decode_pkg::XLEN-1:0]     src_value,
  output logic [decode_pkg::XLEN-1:0]     tgt_value,
  output logic [decode_pkg::XLEN-1:0]     eff_addr,
  output logic [decode_pkg::XLEN-1:0]     phys_addr,
  output logic [decode_pkg::XLEN-1:0]     flow_target,
  output logic                            flow_redirect,
  output logic [decode_pkg::XLEN-1:0]     hi_value,
  output logic [decode_pkg::XLEN-1:0]     lo_value,
  output logic [decode_pkg::XLEN-1:0]     status_value,
  output logic [decode_pkg::XLEN-1:0]     cause_value,
  output logic                            big_endian,
  output logic [decode_pkg::STAGES-1:0]   stage_valid
);
  import decode_pkg::*;

  state_s state_reg;
  state_s state_next;
  logic   accept;

  // split one word into its fields and classify it
  function automatic dec_s decode(input logic [XLEN-1:0] w);
    dec_s d;
    d              = '0;
    d.opcode_field     = w[OPC_HI:OPC_LO];
    d.source_reg_field = w[SRC_HI:SRC_LO];
    d.target_reg_field = w[TGT_HI:TGT_LO];
    d.dest_field       = w[DST_HI:DST_LO];
    d.shamt_field      = w[SHM_HI:SHM_LO];
    d.funct_field      = w[FN_HI:FN_LO];
    d.jump_field       = w[JT_HI:JT_LO];
    d.imm_sext = {{(XLEN-IMM_W){w[IMM_HI]}}, w[IMM_HI:IMM_LO]};
    d.cls      = CLS_COMP;
    d.fmt      = FMT_I;
    d.wr_idx   = d.target_reg_field;
    if (d.opcode_field == OP_SPECIAL) begin
      d.fmt    = FMT_R;
      d.wr_idx = d.dest_field;
      if (d.funct_field == FN_JR || d.funct_field == FN_JALR) begin
        d.cls   = CLS_FLOW;
        d.wr_en = (d.funct_field == FN_JALR);
      end else if (d.funct_field == FN_SYSCALL || d.funct_field == FN_BREAK ||
                   (d.funct_field >= FN_MFHI && d.funct_field <= FN_MTLO)) begin
        d.cls   = CLS_SPEC;
        d.wr_en = (d.funct_field == FN_MFHI || d.funct_field == FN_MFLO);
      end else if ((d.funct_field >= FN_MD_LO && d.funct_field <= FN_MD_HI)) begin
        d.cls   = CLS_COMP;
      end else if (d.funct_field == FN_SLL || d.funct_field == FN_SRL ||
                   d.funct_field == FN_SRA || d.funct_field == FN_SLLV ||
                   d.funct_field == FN_SRLV || d.funct_field == FN_SRAV ||
                   d.funct_field == FN_SLT || d.funct_field == FN_SLTU ||
                   (d.funct_field >= FN_AL_LO && d.funct_field <= FN_AL_HI)) begin
        d.cls   = CLS_COMP;
        d.wr_en = 1'b1;
      end else begin
        d.reserved = 1'b1;
      end
    end else if (d.opcode_field == OP_REGIMM) begin
      d.cls    = CLS_FLOW;
      d.wr_idx = LINK_IDX;
      d.wr_en  = (d.target_reg_field == RI_BLTZAL || d.target_reg_field == RI_BGEZAL);
      d.reserved = !(d.target_reg_field == RI_BLTZ || d.target_reg_field == RI_BGEZ ||
                     d.wr_en);
    end else if (d.opcode_field == OP_J || d.opcode_field == OP_JAL) begin
      d.cls    = CLS_FLOW;
      d.fmt    = FMT_J;
      d.wr_idx = LINK_IDX;
      d.wr_en  = (d.opcode_field == OP_JAL);
    end else if (d.opcode_field >= OP_BEQ && d.opcode_field <= OP_BGTZ) begin
      d.cls = CLS_FLOW;
    end else if (d.opcode_field >= OP_ALUI_LO && d.opcode_field <= OP_ALUI_HI) begin
      d.cls   = CLS_COMP;
      d.wr_en = 1'b1;
    end else if (d.opcode_field >= OP_COP_LO && d.opcode_field <= OP_COP_HI) begin
      d.cls = CLS_COP;
      d.fmt = FMT_R; // format left to the coprocessor
    end else if (d.opcode_field >= OP_LD_LO && d.opcode_field <= OP_LD_HI) begin
      d.cls     = CLS_LDST;
      d.is_load = 1'b1;
      d.wr_en   = 1'b1;
    end else if (d.opcode_field == OP_SB || d.opcode_field == OP_SH ||
                 d.opcode_field == OP_SWL || d.opcode_field == OP_SW ||
                 d.opcode_field == OP_SWR) begin
      d.cls      = CLS_LDST;
      d.is_store = 1'b1;
    end else if (d.opcode_field >= OP_LWC_LO && d.opcode_field <= OP_LWC_HI) begin
      d.cls     = CLS_COP;
      d.is_load = 1'b1;
    end else if (d.opcode_field >= OP_SWC_LO && d.opcode_field <= OP_SWC_HI) begin
      d.cls      = CLS_COP;
      d.is_store = 1'b1;
    end else begin
      d.reserved = 1'b1;
    end
    if (d.reserved) begin
      d.wr_en = 1'b0;
    end
    return d;
  endfunction

  // fixed segment map: two kernel windows fold onto low memory
  function automatic logic [XLEN-1:0] seg_map(input logic [XLEN-1:0] va);
    logic [SEG_W-1:0] seg;
    seg = va[XLEN-1 -: SEG_W];
    if (seg == SEG_K0 || seg == SEG_K1) begin
      return va & SEG_MASK;
    end
    return va;
  endfunction

  // fetch only once byte order is known and nothing downstream holds
  assign accept      = fetch_valid && !stall && state_reg.strap_done;
  assign fetch_ready = !stall && state_reg.strap_done;

  always_comb begin
    dec_s              d;
    logic [XLEN-1:0]   rs_v;
    logic [XLEN-1:0]   rt_v;
    logic [XLEN-1:0]   seq_pc;
    logic              taken;
    logic [CODE_W-1:0] code;
    state_next = state_reg;
    d      = decode(fetch_instr);
    rs_v   = state_reg.gpr[d.source_reg_field];
    rt_v   = state_reg.gpr[d.target_reg_field];
    seq_pc = state_reg.pc + WORD_STEP;
    taken  = 1'b0;
    code   = EXC_NONE;

    // byte order caught on the first edge after reset release
    if (!state_reg.strap_done) begin
      state_next.big_endian = big_endian_strap;
      state_next.strap_done = 1'b1;
    end

    // stage tokens advance together; a stall freezes them all
    if (!stall) begin
      state_next.stage_valid = {state_reg.stage_valid[STAGES-2:0], accept};
    end

    // late-stage results: only the named destination changes
    if (wb_valid) begin
      state_next.gpr[wb_idx] = wb_data;
    end
    if (muldiv_valid) begin
      state_next.hi = muldiv_hi;
      state_next.lo = muldiv_lo;
    end

    state_next.redirect = 1'b0;
    if (accept) begin
      state_next.dec      = d;
      state_next.src_val  = rs_v;
      state_next.tgt_val  = rt_v;
      state_next.eff_addr = rs_v + d.imm_sext;
      state_next.phys_addr = seg_map(rs_v + d.imm_sext);
      // flow decisions test register values, no flags kept
      unique case (d.opcode_field)
        OP_J, OP_JAL: begin
          state_next.flow_target = {state_reg.pc[XLEN-1 -: PAGE_W], d.jump_field,
                                    {WORD_SH{1'b0}}};
          taken = 1'b1;
        end
        OP_SPECIAL: begin
          state_next.flow_target = rs_v;
          taken = (d.cls == CLS_FLOW);
        end
        default: begin
          state_next.flow_target = seq_pc + (d.imm_sext << WORD_SH);
          unique case (d.opcode_field)
            OP_BEQ:    taken = (rs_v == rt_v);
            OP_BNE:    taken = (rs_v != rt_v);
            OP_BLEZ:   taken = rs_v[XLEN-1] || (rs_v == '0);
            OP_BGTZ:   taken = !rs_v[XLEN-1] && (rs_v != '0);
            OP_REGIMM: taken = !d.reserved && (rs_v[XLEN-1] ^ d.target_reg_field[0]);
            default:   taken = 1'b0;
          endcase
        end
      endcase
      if (d.opcode_field == OP_SPECIAL && d.funct_field == FN_MTHI) begin
        state_next.hi = rs_v;
      end
      if (d.opcode_field == OP_SPECIAL && d.funct_field == FN_MTLO) begin
        state_next.lo = rs_v;
      end
      // return address lands in its register; beats a same-cycle writeback
      if (d.wr_en && d.cls == CLS_FLOW) begin
        state_next.gpr[d.wr_idx] = seq_pc;
      end
      state_next.redirect = taken;
      state_next.pc       = taken ? state_next.flow_target : seq_pc;
      if (d.reserved) begin
        code = EXC_RI;
      end else if (d.opcode_field == OP_SPECIAL && d.funct_field == FN_SYSCALL) begin
        code = EXC_SYS;
      end else if (d.opcode_field == OP_SPECIAL && d.funct_field == FN_BREAK) begin
        code = EXC_BRK;
      end
    end

    // overflow comes from an older instruction, so it takes priority
    if (ovf_event) begin
      code = EXC_OV;
    end
    if (exc_ack) begin
      state_next.status[STAT_EXC_BIT] = 1'b0;
    end
    if (code != EXC_NONE) begin
      state_next.status[STAT_EXC_BIT] = 1'b1;
      state_next.cause = '0;
      state_next.cause[CAUSE_CODE_LO +: CODE_W] = code;
    end
    state_next.status[STAT_BE_BIT] = state_next.big_endian;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= '0;
      state_reg.pc <= RESET_PC;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output but fetch_ready straight from the state register
  assign fetch_pc      = state_reg.pc;
  assign dec_out       = state_reg.dec;
  assign src_value     = state_reg.src_val;
  assign tgt_value     = state_reg.tgt_val;
  assign eff_addr      = state_reg.eff_addr;
  assign phys_addr     = state_reg.phys_addr;
  assign flow_target   = state_reg.flow_target;
  assign flow_redirect = state_reg.redirect;
  assign hi_value      = state_reg.hi;
  assign lo_value      = state_reg.lo;
  assign status_value  = state_reg.status;
  assign cause_value   = state_reg.cause;
  assign big_endian    = state_reg.big_endian;
  assign stage_valid   = state_reg.stage_valid;
endmodule

//--- testbench/decoder_checker_assertions.sv
`timescale 1ns/1ps
module decoder_checker
  import decode_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              stall,
  input wire logic              fetch_valid,
  input wire logic              fetch_ready,
  input wire logic [XLEN-1:0]   fetch_instr,
  input wire logic [XLEN-1:0]   fetch_pc,
  input wire logic              ovf_event,
  input wire logic [XLEN-1:0]   src_value,
  input wire logic [XLEN-1:0]   eff_addr,
  input wire logic [XLEN-1:0]   flow_target,
  input wire logic [XLEN-1:0]   status_value,
  input wire logic [XLEN-1:0]   cause_value,
  input wire decode_pkg::dec_s  dec_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // accept strobe and opcode of the word on offer
  logic             acc;
  logic [OPC_W-1:0] opc;
  assign acc = fetch_valid && fetch_ready;
  assign opc = fetch_instr[31:26];
  a_stall_no_ready: assert property (stall |-> !fetch_ready)
    else $error("ready while stalled");
  a_fields_copied: assert property (acc |=> dec_out.opcode_field == $past(opc)
    && dec_out.dest_field == $past(fetch_instr[15:11])
    && dec_out.funct_field == $past(fetch_instr[5:0])) else $error("field split wrong");
  a_imm_sign_ext: assert property (acc |=>
    dec_out.imm_sext == {{16{$past(fetch_instr[15])}}, $past(fetch_instr[15:0])})
    else $error("immediate not sign extended");
  a_eff_base_off: assert property (acc |=> eff_addr == src_value + dec_out.imm_sext)
    else $error("effective address wrong");
  a_alu_imm_seq: assert property (acc && opc inside {[OP_ALUI_LO:OP_ALUI_HI]} |=>
    fetch_pc == $past(fetch_pc) + 32'h0000_0004 && dec_out.fmt == FMT_I)
    else $error("alu immediate decode wrong");
  a_jump_page: assert property (acc && opc == OP_J |=>
    flow_target == {$past(fetch_pc[31:28]), $past(fetch_instr[25:0]), 2'b00})
    else $error("jump target wrong");
  a_special_reg: assert property (acc && opc == OP_SPECIAL |=> dec_out.fmt == FMT_R)
    else $error("special not register layout");
  a_ldst_imm: assert property (acc && opc inside {[OP_LD_LO:OP_LD_HI]} |=>
    dec_out.fmt == FMT_I && dec_out.cls == CLS_LDST) else $error("load decode wrong");
  a_ovf_status: assert property (ovf_event |=>
    status_value[0] && cause_value[6:2] == EXC_OV) else $error("overflow not recorded");
  c_jump: cover property (acc && opc == OP_J);
  c_special: cover property (acc && opc == OP_SPECIAL);
  c_ovf: cover property (ovf_event);
endmodule
bind risc_format_decoder decoder_checker i_chk (.sys_clk, .rst_n, .stall, .fetch_valid,
  .fetch_ready, .fetch_instr, .fetch_pc, .ovf_event, .src_value, .eff_addr, .flow_target,
  .status_value, .cause_value, .dec_out);

//--- testbench/fetch_source.sv
`timescale 1ns/1ps
module fetch_source (
  input  wire logic        sys_clk,
  input  wire logic        fetch_ready,
  output logic             fetch_valid,
  output logic [31:0]      fetch_instr
);
  initial begin
    fetch_valid = 1'b0;
    fetch_instr = 32'h0;
  end
  // hold the word until the accepting edge, then show its inverse
  // so a stale word never passes for a fresh one
  task automatic send(input logic [31:0] w);
    int n = 0;
    @(posedge sys_clk);
    #1;
    fetch_valid = 1'b1;
    fetch_instr = w;
    // ready sampled at the edge itself, so a late rise never double-accepts
    @(posedge sys_clk);
    while (!fetch_ready && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    #1;
    fetch_valid = 1'b0;
    fetch_instr = ~w;
  endtask
endmodule

//--- testbench/risc_instruction_format_decoder_tb.sv
`timescale 1ns/1ps
module risc_instruction_format_decoder_tb;
  import decode_pkg::*;
  logic        sys_clk = 0, rst_n = 1, big_endian_strap = 1, stall = 0;
  logic        wb_valid = 0, muldiv_valid = 0, ovf_event = 0, exc_ack = 0;
  logic [4:0]  wb_idx = 0;
  logic [31:0] wb_data = 0, muldiv_hi = 0, muldiv_lo = 0, pc0;
  logic        fetch_valid, fetch_ready, flow_redirect, big_endian;
  logic [31:0] fetch_instr, fetch_pc, src_value, tgt_value, eff_addr, phys_addr;
  logic [31:0] flow_target, hi_value, lo_value, status_value, cause_value;
  logic [4:0]  stage_valid;
  dec_s        dec_out;
  int          fails = 0, cmp_count = 0;

  always #25 sys_clk = ~sys_clk;

  risc_format_decoder i_dut (.sys_clk, .rst_n, .big_endian_strap, .fetch_valid, .fetch_instr,
    .fetch_ready, .fetch_pc, .stall, .wb_valid, .wb_idx, .wb_data, .muldiv_valid, .muldiv_hi,
    .muldiv_lo, .ovf_event, .exc_ack, .dec_out, .src_value, .tgt_value, .eff_addr, .phys_addr,
    .flow_target, .flow_redirect, .hi_value, .lo_value, .status_value, .cause_value,
    .big_endian, .stage_valid);
  fetch_source p (.sys_clk, .fetch_ready, .fetch_valid, .fetch_instr);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] iw(logic [5:0] op, logic [4:0] s, logic [4:0] t,
                                     logic [15:0] imm);
    return {op, s, t, imm};
  endfunction
  function automatic logic [31:0] rw(logic [4:0] s, logic [4:0] d, logic [5:0] fn);
    return {6'h00, s, 5'h00, d, 5'h00, fn};
  endfunction
  // one-cycle pulses on the side inputs
  task automatic pulse(input int which);
    @(posedge sys_clk);
    #1;
    wb_valid = (which == 0);
    muldiv_valid = (which == 1);
    ovf_event = (which == 2);
    exc_ack = (which == 3);
    @(posedge sys_clk);
    #1;
    {wb_valid, muldiv_valid, ovf_event, exc_ack} = 4'h0;
  endtask

  task automatic t_reset;
    #1;
    rst_n = 0;
    #1;
    chk("ready_in_reset", fetch_ready, 0);
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1;
    @(posedge sys_clk);
    #1;
    chk("byte_order", big_endian, 1);
    chk("status_be", status_value[1], 1);
  endtask
  task automatic t_alu;
    pc0 = fetch_pc;
    p.send(iw(6'h09, 5'd3, 5'd4, 16'h8001));
    chk("src_f", dec_out.source_reg_field, 3);
    chk("tgt_f", dec_out.target_reg_field, 4);
    chk("imm", dec_out.imm_sext, 32'hffff_8001);
    chk("alu_cls", dec_out.cls, CLS_COMP);
    chk("seq_pc", fetch_pc, pc0 + 32'h4);
    chk("stage0", stage_valid[0], 1);
    p.send(rw(5'd1, 5'd7, FN_AL_LO));
    chk("r_fmt", dec_out.fmt, FMT_R);
    chk("wr_idx", dec_out.wr_idx, 7);
    chk("wr_en", dec_out.wr_en, 1);
  endtask
  task automatic t_ldst;
    wb_idx = 5'd5;
    wb_data = 32'h8000_1000;
    pulse(0);
    p.send(iw(6'h23, 5'd5, 5'd9, 16'hfff0));
    chk("eff", eff_addr, 32'h8000_0ff0);
    chk("src_val", src_value, 32'h8000_1000);
    chk("phys", phys_addr, 32'h0000_0ff0);
    chk("is_load", dec_out.is_load, 1);
    p.send(iw(OP_SW, 5'd5, 5'd9, 16'h0010));
    chk("is_store", dec_out.is_store, 1);
    p.send(iw(OP_LWC_LO + 6'h1, 5'd5, 5'd2, 16'h0004));
    chk("cop_fmt", dec_out.fmt, FMT_I);
    chk("cop_cls", dec_out.cls, CLS_COP);
  endtask
  task automatic t_flow;
    logic [31:0] exp;
    pc0 = fetch_pc;
    exp = {pc0[31:28], 26'h000_0040, 2'b00};
    p.send({OP_JAL, 26'h000_0040});
    chk("jal_tgt", flow_target, exp);
    chk("jal_pc", fetch_pc, exp);
    chk("redir", flow_redirect, 1);
    @(posedge sys_clk);
    #1;
    chk("redir_end", flow_redirect, 0);
    p.send(rw(5'd31, 5'd0, FN_JR));
    chk("link_ret", flow_target, pc0 + 32'h4);
    chk("jr_fmt", dec_out.fmt, FMT_R);
    pc0 = fetch_pc;
    p.send(iw(OP_BEQ, 5'd0, 5'd0, 16'hffff));
    chk("br_tgt", flow_target, pc0);
    chk("br_pc", fetch_pc, pc0);
  endtask
  task automatic t_exc;
    p.send(iw(6'h3f, 5'd0, 5'd0, 16'h0));
    chk("resv", dec_out.reserved, 1);
    chk("ri_code", cause_value[6:2], EXC_RI);
    p.send(rw(5'd0, 5'd0, FN_SYSCALL));
    chk("sys_code", cause_value[6:2], EXC_SYS);
    pulse(3);
    chk("ack", status_value[0], 0);
    pulse(2);
    chk("ov_code", cause_value[6:2], EXC_OV);
    muldiv_hi = 32'haaaa_0001;
    muldiv_lo = 32'h5555_0002;
    pulse(1);
    chk("hi", hi_value, 32'haaaa_0001);
    chk("lo", lo_value, 32'h5555_0002);
  endtask
  task automatic t_stall;
    int n = 0;
    pc0 = fetch_pc;
    stall = 1;
    fork
      p.send(iw(6'h0d, 5'd1, 5'd2, 16'h0003));
    join_none
    repeat (3) @(posedge sys_clk);
    #1;
    chk("stall_rdy", fetch_ready, 0);
    chk("stall_pc", fetch_pc, pc0);
    stall = 0;
    while (fetch_valid && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("resume_pc", fetch_pc, pc0 + 32'h4);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  initial begin
    t_reset;
    t_alu;
    t_ldst;
    t_flow;
    t_exc;
    t_stall;
    wrap_up;
  end
endmodule
